/* bench/root_hub_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module root_hub_port_chk #(
  parameter RESET_CYCLES = 20
) (
  input wire       i_clk,
  input wire       i_sys_rst,
  input wire       i_clk_en,
  input wire       i_hsel,
  input wire [1:0] i_htrans,
  input wire       i_hwrite,
  input wire       i_hready,
  input wire       i_device_present,
  input wire       i_overcurrent,
  input wire       o_hreadyout,
  input wire       o_hresp,
  input wire       o_port_power,
  input wire       o_reset_drive,
  input wire       o_resume_drive
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  wire       taken = i_hsel & i_htrans[1] & i_hready & i_clk_en;
  reg        wr_dp;
  reg [31:0] rcnt;
  // Helper state: write data phase marker and reset pulse length
  always @(posedge i_clk) begin
    wr_dp <= taken & i_hwrite;
    rcnt  <= o_reset_drive ? rcnt + 32'h1 : 32'h0;
  end
  sequence rd_req;
    taken && !i_hwrite;
  endsequence
  sequence rd_wait;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  sequence oc_held;
    i_overcurrent [*6];
  endsequence
  a_hresp_okay: assert property (!o_hresp)
    else $error("bus response not okay");
  a_read_wait: assert property (rd_req |=> rd_wait)
    else $error("read wait state wrong");
  a_write_nowait: assert property (taken && i_hwrite |=> o_hreadyout)
    else $error("write stalled");
  a_oc_power_off: assert property (oc_held |-> !o_port_power)
    else $error("power on during overcurrent");
  a_power_rise_cause: assert property ($rose(o_port_power) |-> $past(wr_dp))
    else $error("power rose without a write");
  a_unpowered_quiet: assert property (
    !o_port_power [*2] |-> !o_reset_drive && !o_resume_drive)
    else $error("port signalling while unpowered");
  a_reset_bounded: assert property (o_reset_drive |-> rcnt <= RESET_CYCLES)
    else $error("reset signalling too long");
  a_reset_attached: assert property ($rose(o_reset_drive) |->
    $past(i_device_present, 4) || $past(i_device_present, 5) ||
    $past(i_device_present, 6) || $past(i_device_present, 7))
    else $error("reset started while detached");
endmodule
bind root_hub_port_power_reset_status root_hub_port_chk #(.RESET_CYCLES(RESET_CYCLES)) chk_u (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_hsel(i_hsel),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
  .i_device_present(i_device_present), .i_overcurrent(i_overcurrent),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_port_power(o_port_power),
  .o_reset_drive(o_reset_drive), .o_resume_drive(o_resume_drive));
`default_nettype wire

/* bench/root_hub_port_power_reset_status_test.sv */
`timescale 1ns/1ps
`default_nettype none
module root_hub_port_power_reset_status_test;
  localparam int RC = 20;
  logic        clk;
  logic        rst;
  logic        hsel;
  logic        hwrite;
  logic        plug;
  logic        fault;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] rd;
  wire  [31:0] hrdata;
  wire  [31:0] rlen;
  wire         hready;
  wire         hresp;
  wire         pwr;
  wire         rst_drv;
  wire         res_drv;
  wire         irq;
  wire         present;
  wire         oc;
  wire         fixed_pwr;
  int          fails;
  int          tests_run;

  root_hub_port_power_reset_status #(
    .POWER_SWITCHED(1), .CNT_W(23), .RESET_CYCLES(RC), .RESUME_CYCLES(30)
  ) dut_u (
    .i_clk(clk), .i_clk_en(1'h1), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hready(hready),
    .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_device_present(present), .i_overcurrent(oc), .o_port_power(pwr),
    .o_reset_drive(rst_drv), .o_resume_drive(res_drv), .o_irq(irq));
  usb_port_device_model dev_u (
    .i_clk(clk), .i_plug(plug), .i_fault(fault), .i_port_power(pwr),
    .i_reset_drive(rst_drv), .o_present(present), .o_overcurrent(oc), .o_reset_len(rlen));
  root_hub_port_power_reset_status #(
    .POWER_SWITCHED(0), .CNT_W(23), .RESET_CYCLES(RC), .RESUME_CYCLES(30)
  ) fixed_u (
    .i_clk(clk), .i_clk_en(1'h1), .i_sys_rst(rst), .i_hsel(1'h0), .i_haddr(32'h0),
    .i_htrans(2'h0), .i_hwrite(1'h0), .i_hsize(3'h2), .i_hready(1'h1),
    .i_hwdata(32'h0), .o_hrdata(), .o_hreadyout(), .o_hresp(),
    .i_device_present(1'h0), .i_overcurrent(1'h0), .o_port_power(fixed_pwr),
    .o_reset_drive(), .o_resume_drive(), .o_irq());

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang(input string what, input int n, input int lim);
    if (n >= lim) begin
      fails++;
      $display("Error %s expected done seen timeout", what);
      stop_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'h1 && n < 50);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'h1 && n < 100);
    rd = hrdata;
    hang("bus", n, 100);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(what, e, rd & m);
  endtask
  // Bounded wait for reset (sel 0) or resume (sel 1) signalling to end
  task automatic wait_drop(input bit sel);
    int n;
    n = 0;
    while ((sel ? res_drv : rst_drv) === 1'h1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    hang("drive end", n, 300);
    repeat (2) @(posedge clk);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs;
    rdc("ctrl", 8'h04, 32'hffffffff, 32'h10);
    rdc("mask", 8'h0c, 32'hffffffff, 32'h0);
    rdc("status", 8'h00, 32'hffffffff, 32'h0);
    wr(8'h00, 32'he0);
    rdc("reserved", 8'h00, 32'he0, 32'h0);
    wr(8'h40, 32'hffffffff);
    rdc("unmapped", 8'h40, 32'hffffffff, 32'h0);
    chk("irq", 32'h0, irq);
    chk("hresp", 32'h0, hresp);
    chk("fixed power", 32'h1, fixed_pwr);
    $display("t_regs done");
  endtask
  task automatic t_power;
    logic pp;
    for (int k = 0; k < 4; k++) begin
      pp = k[0] & k[1];
      wr(8'h04, 32'h18 | 32'(k));
      wr(8'h00, 32'h200);
      rdc("power off", 8'h00, 32'h100, 32'h0);
      wr(8'h00, 32'h100);
      rdc("port on", 8'h00, 32'h100, 32'(pp) << 8);
      chk("power pin", 32'(pp), pwr);
      wr(8'h04, 32'h14 | 32'(k));
      wr(8'h00, 32'h0);
      rdc("global on", 8'h00, 32'h100, 32'h100);
      wr(8'h00, 32'h200);
      rdc("port off", 8'h00, 32'h100, 32'(!pp) << 8);
      wr(8'h04, 32'h18 | 32'(k));
      rdc("global off", 8'h00, 32'h100, 32'h0);
    end
    $display("t_power done");
  endtask
  task automatic t_reset;
    wr(8'h04, 32'h10);
    wr(8'h04, 32'h14);
    wr(8'h0c, 32'hf);
    wr(8'h00, 32'h10);
    rdc("refused", 8'h00, 32'h10010, 32'h10000);
    wr(8'h00, 32'h10000);
    rdc("chg clear", 8'h00, 32'h10000, 32'h0);
    wr(8'h08, 32'hf);
    plug <= 1'h1;
    repeat (8) @(posedge clk);
    rdc("attach", 8'h00, 32'h10001, 32'h10001);
    chk("irq attach", 32'h1, irq);
    wr(8'h08, 32'hf);
    wr(8'h00, 32'h10000);
    wr(8'h00, 32'h10);
    rdc("active", 8'h00, 32'h10, 32'h10);
    wait_drop(1'b0);
    rdc("done", 8'h00, 32'h100016, 32'h100002);
    chk("length", RC, rlen);
    rdc("irq stat", 8'h08, 32'h2, 32'h2);
    chk("irq done", 32'h1, irq);
    wr(8'h00, 32'h0);
    rdc("w0 keeps", 8'h00, 32'h100000, 32'h100000);
    wr(8'h00, 32'h100000);
    rdc("w1 clears", 8'h00, 32'h100000, 32'h0);
    wr(8'h08, 32'hf);
    @(posedge clk);
    chk("irq clear", 32'h0, irq);
    $display("t_reset done");
  endtask
  task automatic t_resume;
    wr(8'h00, 32'h8);
    @(posedge clk);
    chk("no resume", 32'h0, res_drv);
    wr(8'h00, 32'h4);
    rdc("suspended", 8'h00, 32'h4, 32'h4);
    wr(8'h00, 32'h8);
    @(posedge clk);
    chk("resume", 32'h1, res_drv);
    wait_drop(1'b1);
    rdc("resumed", 8'h00, 32'h40004, 32'h40000);
    $display("t_resume done");
  endtask
  task automatic t_oc;
    fault <= 1'h1;
    repeat (8) @(posedge clk);
    rdc("oc on", 8'h00, 32'h11f, 32'h8);
    chk("oc pin", 32'h0, pwr);
    rdc("oc irq", 8'h08, 32'h8, 32'h8);
    fault <= 1'h0;
    repeat (8) @(posedge clk);
    rdc("oc off", 8'h00, 32'h8, 32'h0);
    wr(8'h04, 32'h04);
    fault <= 1'h1;
    repeat (8) @(posedge clk);
    rdc("oc hidden", 8'h00, 32'h8, 32'h0);
    fault <= 1'h0;
    $display("t_oc done");
  endtask

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst       = 1'h1;
    hsel      = 1'h0;
    hwrite    = 1'h0;
    plug      = 1'h0;
    fault     = 1'h0;
    htrans    = 2'h0;
    haddr     = 32'h0;
    hwdata    = 32'h0;
    fails     = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    t_regs();
    t_power();
    t_reset();
    t_resume();
    t_oc();
    stop_test();
  end
endmodule
`default_nettype wire

/* bench/usb_port_device_model.sv */
`timescale 1ns/1ps
`default_nettype none
module usb_port_device_model (
  input  wire logic        i_clk,
  input  wire logic        i_plug,
  input  wire logic        i_fault,
  input  wire logic        i_port_power,
  input  wire logic        i_reset_drive,
  output wire logic        o_present,
  output wire logic        o_overcurrent,
  output var  logic [31:0] o_reset_len
);
  logic [31:0] cnt_reg;
  // A device only shows itself once the port feeds it
  assign o_present     = i_plug & i_port_power;
  assign o_overcurrent = i_fault;
  initial begin
    cnt_reg     = 32'h0;
    o_reset_len = 32'h0;
  end
  // Length of the last reset burst, so the bench can judge it at the wire
  always @(posedge i_clk) begin
    if (i_reset_drive) begin
      cnt_reg <= cnt_reg + 32'h1;
    end else begin
      if (cnt_reg != 32'h0) begin
        o_reset_len <= cnt_reg;
      end
      cnt_reg <= 32'h0;
    end
  end
endmodule
`default_nettype wire

/* hw/pin_sync3.v */
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
  parameter RESET_VALUE = 1'b0
) (
  input  wire i_clk,
  input  wire i_clk_en,
  input  wire i_sys_rst,
  input  wire i_async,
  output reg  o_level
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // A change is taken only once stages two and three agree
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      s1_reg  <= RESET_VALUE;
      s2_reg  <= RESET_VALUE;
      s3_reg  <= RESET_VALUE;
      o_level <= RESET_VALUE;
    end else if (i_clk_en) begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        o_level <= s3_reg;
      end
    end
  end

endmodule

`default_nettype wire

/* hw/root_hub_port_power_reset_status.v */
//
// Functional notes
// [RULE1] Power bit reports power applied to port
// [RULE2] Overcurrent clears the power bit
// [RULE3] Power set and cleared by port/global commands
// [RULE4] Scheme 0: only global commands affect power
// [RULE5] Scheme 1: mask picks port or global commands
// [RULE6] Power off clears connect, enable, suspend, reset
// [RULE7] Write 1 to bit 8 powers port on
// [RULE8] Without power switching, power reads 1
// [RULE9] Bit 4 shows reset signalling active
// [RULE10] Reset never starts while disconnected
// [RULE11] Reset write when disconnected sets attach change
// [RULE12] Overcurrent bit zero without per-port reporting
// [RULE13] Overcurrent bit follows the overcurrent input
// [RULE14] Write 1 to bit 3 resumes suspended port
// [RULE15] Reset end sets sticky change, write-1 clear
// [RULE16] Attach change on connect/disconnect, write-1 clear
// [RULE17] Bits 7 to 5 read zero, ignore writes
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "root_hub_port_regs.vh"

module root_hub_port_power_reset_status #(
  parameter POWER_SWITCHED = 1,
  parameter CNT_W          = 23,
  parameter RESET_CYCLES   = `RESET_CYCLES,
  parameter RESUME_CYCLES  = `RESUME_CYCLES
) (
  input  wire        i_clk,
  input  wire        i_clk_en,
  input  wire        i_sys_rst,
  input  wire        i_hsel,
  input  wire [31:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire        i_hready,
  input  wire [31:0] i_hwdata,
  output reg  [31:0] o_hrdata,
  output reg         o_hreadyout,
  output reg         o_hresp,
  input  wire        i_device_present,
  input  wire        i_overcurrent,
  output reg         o_port_power,
  output reg         o_reset_drive,
  output reg         o_resume_drive,
  output reg         o_irq
);

  localparam integer     RESET_LOAD_I  = RESET_CYCLES - 1;
  localparam integer     RESUME_LOAD_I = RESUME_CYCLES - 1;
  localparam [CNT_W-1:0] RESET_LOAD    = RESET_LOAD_I[CNT_W-1:0];
  localparam [CNT_W-1:0] RESUME_LOAD   = RESUME_LOAD_I[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_ZERO    = {CNT_W{1'b0}};

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // Sticky flag: a set in the same cycle as a clear wins
  function sticky;
    input cur;
    input set;
    input clr;
    begin
      sticky = set | (cur & ~clr);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  wire present_level;
  wire oc_level;

  pin_sync3 #(
    .RESET_VALUE (1'b0)
  ) u_present_sync (
    .i_clk     (i_clk),
    .i_clk_en  (i_clk_en),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_device_present),
    .o_level   (present_level)
  );

  pin_sync3 #(
    .RESET_VALUE (1'b0)
  ) u_oc_sync (
    .i_clk     (i_clk),
    .i_clk_en  (i_clk_en),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_overcurrent),
    .o_level   (oc_level)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg             wr_pend_reg;
  reg             rd_pend_reg;
  reg [7:0]       addr_reg;
  reg [4:0]       ctrl_reg;
  reg [`IRQ_WIDTH-1:0] int_stat_reg;
  reg [`IRQ_WIDTH-1:0] int_mask_reg;
  reg             power_reg;
  reg             attached_d_reg;
  reg             oc_d_reg;
  reg             enabled_reg;
  reg             suspended_reg;
  reg             resuming_reg;
  reg             reset_active_reg;
  reg             attach_chg_reg;
  reg             suspend_chg_reg;
  reg             reset_chg_reg;
  reg [CNT_W-1:0] rst_cnt_reg;
  reg [CNT_W-1:0] res_cnt_reg;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire accept = i_hsel & i_htrans[1] & i_hready;
  wire wr_port  = wr_pend_reg & hit(addr_reg, `PORT_STATUS_OFS);
  wire wr_ctrl  = wr_pend_reg & hit(addr_reg, `PORT_CTRL_OFS);
  wire wr_istat = wr_pend_reg & hit(addr_reg, `INT_STATUS_OFS);
  wire wr_imask = wr_pend_reg & hit(addr_reg, `INT_MASK_OFS);

  // ----------------------------------------------------------------------
  // Power control
  // ----------------------------------------------------------------------
  wire per_port_sel = ctrl_reg[`PC_SCHEME_BIT] & ctrl_reg[`PC_MASK_BIT]; // RULE4 RULE5
  wire port_on   = wr_port & i_hwdata[`PS_POWER_BIT] & per_port_sel;     // RULE7
  wire port_off  = wr_port & i_hwdata[`PS_POWER_OFF_BIT] & per_port_sel;
  wire global_on = wr_ctrl & i_hwdata[`PC_GLOBAL_ON_BIT] & ~per_port_sel; // RULE4
  wire global_off = wr_ctrl & i_hwdata[`PC_GLOBAL_OFF_BIT] & ~per_port_sel;

  reg power_next;
  always @* begin
    power_next = power_reg;
    if (POWER_SWITCHED == 0) begin
      power_next = 1'b1; // RULE8
    end else if (oc_level) begin
      power_next = 1'b0; // RULE2
    end else if (port_off | global_off) begin
      power_next = 1'b0; // RULE3
    end else if (port_on | global_on) begin
      power_next = 1'b1; // RULE3
    end
  end

  // Power loss hides the attached device, so connect status drops too
  wire power_drop = power_reg & ~power_next; // RULE6
  wire attached   = power_reg & present_level;
  wire attach_evt = attached ^ attached_d_reg;
  wire detach     = attached_d_reg & ~attached;
  wire oc_ind     = ctrl_reg[`PC_OC_PER_PORT_BIT] & oc_level; // RULE12 RULE13
  wire oc_rise    = oc_ind & ~oc_d_reg;

  // ----------------------------------------------------------------------
  // Reset and resume sequencing
  // ----------------------------------------------------------------------
  wire reset_req  = wr_port & i_hwdata[`PS_RESET_ACTIVE_BIT];
  wire reset_go   = reset_req & attached & ~reset_active_reg & ~power_drop; // RULE10
  wire reset_nc   = reset_req & ~attached; // RULE11
  wire reset_done = reset_active_reg & (rst_cnt_reg == CNT_ZERO) &
                    ~power_drop & ~detach; // RULE9
  wire resume_go  = wr_port & i_hwdata[`PS_OVERCURRENT_BIT] &
                    suspended_reg & ~resuming_reg; // RULE14
  wire resume_done = resuming_reg & (res_cnt_reg == CNT_ZERO);
  wire suspend_req = wr_port & i_hwdata[`PS_SUSPENDED_BIT];
  wire enable_req  = wr_port & i_hwdata[`PS_ENABLED_BIT];
  wire disable_req = wr_port & i_hwdata[`PS_ATTACHED_BIT];
  wire attach_set  = attach_evt | reset_nc |
                     ((suspend_req | enable_req) & ~attached); // RULE16

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  reg [31:0] rdata;
  always @* begin
    rdata = 32'h0000_0000; // RULE17
    if (hit(addr_reg, `PORT_STATUS_OFS)) begin
      rdata[`PS_ATTACHED_BIT]     = attached;
      rdata[`PS_ENABLED_BIT]      = enabled_reg;
      rdata[`PS_SUSPENDED_BIT]    = suspended_reg;
      rdata[`PS_OVERCURRENT_BIT]  = oc_ind; // RULE13
      rdata[`PS_RESET_ACTIVE_BIT] = reset_active_reg; // RULE9
      rdata[`PS_POWER_BIT]        = power_reg; // RULE1
      rdata[`PS_ATTACH_CHG_BIT]   = attach_chg_reg;
      rdata[`PS_SUSPEND_CHG_BIT]  = suspend_chg_reg;
      rdata[`PS_RESET_CHG_BIT]    = reset_chg_reg;
    end else if (hit(addr_reg, `PORT_CTRL_OFS)) begin
      rdata[`PC_SCHEME_BIT]      = ctrl_reg[`PC_SCHEME_BIT];
      rdata[`PC_MASK_BIT]        = ctrl_reg[`PC_MASK_BIT];
      rdata[`PC_OC_PER_PORT_BIT] = ctrl_reg[`PC_OC_PER_PORT_BIT];
    end else if (hit(addr_reg, `INT_STATUS_OFS)) begin
      rdata[`IRQ_WIDTH-1:0] = int_stat_reg;
    end else if (hit(addr_reg, `INT_MASK_OFS)) begin
      rdata[`IRQ_WIDTH-1:0] = int_mask_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------------
  reg [`IRQ_WIDTH-1:0] irq_set;
  always @* begin
    irq_set = {`IRQ_WIDTH{1'b0}};
    irq_set[`IRQ_ATTACH_BIT]      = attach_set;
    irq_set[`IRQ_RESET_DONE_BIT]  = reset_done;
    irq_set[`IRQ_RESUME_DONE_BIT] = resume_done;
    irq_set[`IRQ_OVERCURRENT_BIT] = oc_rise;
  end

  wire [`IRQ_WIDTH-1:0] irq_clr = wr_istat ? i_hwdata[`IRQ_WIDTH-1:0] :
                                  {`IRQ_WIDTH{1'b0}};
  wire [`IRQ_WIDTH-1:0] int_stat_next = irq_set | (int_stat_reg & ~irq_clr);

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  // Reads take one wait state so that a write in the preceding data
  // phase is already visible in the returned word.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else if (i_clk_en) begin
      o_hresp <= 1'b0;
      if (rd_pend_reg) begin
        o_hrdata    <= rdata;
        o_hreadyout <= 1'b1;
        rd_pend_reg <= 1'b0;
      end else begin
        wr_pend_reg <= accept & i_hwrite;
        rd_pend_reg <= accept & ~i_hwrite;
        o_hreadyout <= ~(accept & ~i_hwrite);
        if (accept) begin
          addr_reg <= i_haddr[7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Port state
  // ----------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_reg         <= `PORT_CTRL_RESET;
      int_stat_reg     <= {`IRQ_WIDTH{1'b0}};
      int_mask_reg     <= `INT_MASK_RESET;
      power_reg        <= (POWER_SWITCHED == 0) ? 1'b1 : `POWER_RESET;
      attached_d_reg   <= 1'b0;
      oc_d_reg         <= 1'b0;
      enabled_reg      <= 1'b0;
      suspended_reg    <= 1'b0;
      resuming_reg     <= 1'b0;
      reset_active_reg <= 1'b0;
      attach_chg_reg   <= 1'b0;
      suspend_chg_reg  <= 1'b0;
      reset_chg_reg    <= 1'b0;
      rst_cnt_reg      <= CNT_ZERO;
      res_cnt_reg      <= CNT_ZERO;
      o_port_power     <= (POWER_SWITCHED == 0) ? 1'b1 : `POWER_RESET; // RULE8
      o_reset_drive    <= 1'b0;
      o_resume_drive   <= 1'b0;
      o_irq            <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_ctrl) begin
        ctrl_reg[`PC_SCHEME_BIT]      <= i_hwdata[`PC_SCHEME_BIT];
        ctrl_reg[`PC_MASK_BIT]        <= i_hwdata[`PC_MASK_BIT];
        ctrl_reg[`PC_OC_PER_PORT_BIT] <= i_hwdata[`PC_OC_PER_PORT_BIT];
      end
      if (wr_imask) begin
        int_mask_reg <= i_hwdata[`IRQ_WIDTH-1:0];
      end
      int_stat_reg   <= int_stat_next;
      o_irq          <= |(int_stat_next & int_mask_reg);
      power_reg      <= power_next;
      o_port_power   <= power_next;
      attached_d_reg <= attached;
      oc_d_reg       <= oc_ind;

      // Change flags, write one to clear
      attach_chg_reg <= sticky(attach_chg_reg, attach_set,
                               wr_port & i_hwdata[`PS_ATTACH_CHG_BIT]); // RULE16
      reset_chg_reg <= sticky(reset_chg_reg, reset_done,
                              wr_port & i_hwdata[`PS_RESET_CHG_BIT]); // RULE15
      if (reset_done) begin
        suspend_chg_reg <= 1'b0;
      end else begin
        suspend_chg_reg <= sticky(suspend_chg_reg, resume_done,
                                  wr_port & i_hwdata[`PS_SUSPEND_CHG_BIT]);
      end

      // Reset signalling
      if (power_drop | detach) begin
        reset_active_reg <= 1'b0; // RULE6
        o_reset_drive    <= 1'b0;
      end else if (reset_go) begin
        reset_active_reg <= 1'b1; // RULE9
        o_reset_drive    <= 1'b1;
        rst_cnt_reg      <= RESET_LOAD;
      end else if (reset_done) begin
        reset_active_reg <= 1'b0; // RULE9 RULE15
        o_reset_drive    <= 1'b0;
      end else if (reset_active_reg) begin
        rst_cnt_reg <= rst_cnt_reg - 1'b1;
      end

      // Resume signalling
      if (power_drop | detach | reset_go) begin
        resuming_reg   <= 1'b0;
        o_resume_drive <= 1'b0;
      end else if (resume_go) begin
        resuming_reg   <= 1'b1; // RULE14
        o_resume_drive <= 1'b1;
        res_cnt_reg    <= RESUME_LOAD;
      end else if (resume_done) begin
        resuming_reg   <= 1'b0;
        o_resume_drive <= 1'b0;
      end else if (resuming_reg) begin
        res_cnt_reg <= res_cnt_reg - 1'b1;
      end

      // Suspend status
      if (power_drop | detach | reset_done | resume_done) begin
        suspended_reg <= 1'b0; // RULE6
      end else if (suspend_req & attached & enabled_reg) begin
        suspended_reg <= 1'b1;
      end

      // Enable status
      if (power_drop | detach | oc_level | disable_req) begin
        enabled_reg <= 1'b0; // RULE6
      end else if (reset_done | (enable_req & attached)) begin
        enabled_reg <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* inc/root_hub_port_regs.vh */
`ifndef ROOT_HUB_PORT_REGS_VH
`define ROOT_HUB_PORT_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define PORT_STATUS_OFS      8'h00
`define PORT_CTRL_OFS        8'h04
`define INT_STATUS_OFS       8'h08
`define INT_MASK_OFS         8'h0c

// ----------------------------------------------------------------------
// Port status word fields
// ----------------------------------------------------------------------
`define PS_ATTACHED_BIT      0
`define PS_ENABLED_BIT       1
`define PS_SUSPENDED_BIT     2
`define PS_OVERCURRENT_BIT   3
`define PS_RESET_ACTIVE_BIT  4
`define PS_POWER_BIT         8
`define PS_POWER_OFF_BIT     9
`define PS_ATTACH_CHG_BIT    16
`define PS_SUSPEND_CHG_BIT   18
`define PS_RESET_CHG_BIT     20

// ----------------------------------------------------------------------
// Port control word fields
// ----------------------------------------------------------------------
`define PC_SCHEME_BIT        0
`define PC_MASK_BIT          1
`define PC_GLOBAL_ON_BIT     2
`define PC_GLOBAL_OFF_BIT    3
`define PC_OC_PER_PORT_BIT   4

// ----------------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------------
`define IRQ_ATTACH_BIT       0
`define IRQ_RESET_DONE_BIT   1
`define IRQ_RESUME_DONE_BIT  2
`define IRQ_OVERCURRENT_BIT  3
`define IRQ_WIDTH            4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PORT_CTRL_RESET      5'h10
`define INT_MASK_RESET       4'h0
`define POWER_RESET          1'b0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_CYCLES_PER_MS    200000
`define RESET_TIME_MS        10
`define RESUME_TIME_MS       20
`define RESYNC_TIME_MS       3
`define RESET_CYCLES         (`RESET_TIME_MS * `CLK_CYCLES_PER_MS)
`define RESUME_CYCLES        ((`RESUME_TIME_MS + `RESYNC_TIME_MS) * `CLK_CYCLES_PER_MS)

`endif
